// [hdl/control_function_word_upper.sv]
`timescale 1ns/1ps
`default_nettype none
`include "control_word_defines.svh"

module control_function_word_upper #(
    parameter int SAMPLE_W = 18,
    parameter int FLUSH_CYCLES = `CLEAR_FLUSH_CYCLES,
    parameter int RESET_CYCLES = `CLEAR_RESET_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    // register port from the serial controller, whole word per write
    input wire logic [4:0] reg_addr,
    input wire logic reg_write,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // transfer strobe and profile select
    input wire logic io_update,
    input wire logic [2:0] profile,
    // external keying pin
    input wire logic output_amplitude_keying_pin,
    // baseband samples into the comb-integrator filter
    input wire logic [SAMPLE_W-1:0] baseband_sample,
    output logic [SAMPLE_W-1:0] comb_integrator_filter_sample,
    output logic comb_integrator_filter_acc_reset,
    output logic comb_integrator_filter_clear_busy,
    // applied controls
    output logic playback_enable,
    output logic playback_to_iq,
    output logic playback_to_scaling,
    output control_word_pkg::op_mode_t operating_mode,
    output logic keying_enable,
    output logic keying_auto,
    output logic keying_manual,
    output logic keying_pin_level,
    output logic inverse_sinc_enable,
    output logic tone_sine_select
);
    import control_word_pkg::*;

    // written value, as software reads it back
    logic [31:0] shadow_reg, shadow_next;
    // last profile seen, for change detection
    logic [2:0] profile_reg, profile_next;
    // applied controls, one flop each so outputs come straight from flops
    logic playback_enable_reg, playback_enable_next;
    logic playback_to_iq_reg, playback_to_iq_next;
    logic playback_to_scaling_reg, playback_to_scaling_next;
    op_mode_t mode_reg, mode_next;
    logic keying_enable_reg, keying_enable_next;
    logic keying_auto_reg, keying_auto_next;
    logic keying_manual_reg, keying_manual_next;
    logic keying_pin_gate_reg, keying_pin_gate_next; // pin allowed to act
    logic keying_level_reg, keying_level_next;
    logic inv_sinc_reg, inv_sinc_next;
    logic tone_sine_reg, tone_sine_next;
    // read data and filter feed
    logic [31:0] rdata_reg, rdata_next;
    logic [SAMPLE_W-1:0] sample_reg, sample_next;
    logic acc_reset_reg, acc_reset_next;
    logic clear_busy_reg, clear_busy_next;

    // helpers
    logic transfer; // buffered fields move to the logic this cycle
    logic write_hit; // write addressed to this word
    logic clear_start; // launch a filter clear
    logic seq_force_zero; // sequencer feeding zeros
    logic seq_acc_reset; // sequencer resetting accumulators
    logic seq_busy; // clear in progress
    logic seq_done; // clear finished this cycle

    // the clear sequence lives in its own module so its timing can be
    // tuned without touching the register logic
    filter_clear_seq #(
        .FLUSH_CYCLES(FLUSH_CYCLES),
        .RESET_CYCLES(RESET_CYCLES)
    ) u_clear (
        .clock(clock),
        .rst(rst),
        .start(clear_start),
        .force_zero(seq_force_zero),
        .acc_reset(seq_acc_reset),
        .busy(seq_busy),
        .done(seq_done)
    );

    // strobe decode
    always_comb begin
        write_hit = reg_write && (reg_addr == `CFW_ADDR);
        // a profile change counts the same as the strobe
        transfer = io_update || (profile != profile_reg);
        // the clear bit acts on transfer like the other fields; a transfer
        // while one runs starts nothing, and the run's end then clears the request bit
        clear_start = transfer && shadow_reg[`CFW_FILTER_CLEAR_BIT] && !seq_busy;
    end

    // shadow word and profile tracker
    always_comb begin
        shadow_next = shadow_reg;
        profile_next = profile;
        // hardware clear of the request bit once the sequence completes
        if (seq_done) begin
            shadow_next[`CFW_FILTER_CLEAR_BIT] = 1'b0;
        end
        // a write lands after the clear, so a request written in the completing cycle is kept
        if (write_hit) begin
            // open bits are masked so they store nothing and read zero
            shadow_next = reg_wdata & `CFW_WRITE_MASK;
        end
    end

    // applied controls: only move on transfer, so half-written
    // configurations never reach the datapath
    always_comb begin
        playback_enable_next = playback_enable_reg;
        playback_to_iq_next = playback_to_iq_reg;
        playback_to_scaling_next = playback_to_scaling_reg;
        mode_next = mode_reg;
        keying_enable_next = keying_enable_reg;
        keying_auto_next = keying_auto_reg;
        keying_manual_next = keying_manual_reg;
        keying_pin_gate_next = keying_pin_gate_reg;
        inv_sinc_next = inv_sinc_reg;
        tone_sine_next = tone_sine_reg;
        if (transfer) begin
            playback_enable_next = shadow_reg[`CFW_PLAYBACK_EN_BIT];
            // routing means nothing while playback is off
            playback_to_iq_next = shadow_reg[`CFW_PLAYBACK_EN_BIT]
                && shadow_reg[`CFW_PLAYBACK_DEST_BIT];
            playback_to_scaling_next = shadow_reg[`CFW_PLAYBACK_EN_BIT]
                && !shadow_reg[`CFW_PLAYBACK_DEST_BIT];
            // upper mode bit alone selects the DAC mode
            unique casez (shadow_reg[`CFW_MODE_HI_BIT:`CFW_MODE_LO_BIT])
                `CFW_MODE_QUAD: mode_next = MODE_QUADRATURE;
                `CFW_MODE_TONE: mode_next = MODE_SINGLE_TONE;
                default: mode_next = MODE_INTERP_DAC;
            endcase
            keying_enable_next = shadow_reg[`CFW_KEY_EN_BIT];
            // auto select is ignored unless keying is enabled
            keying_auto_next = shadow_reg[`CFW_KEY_EN_BIT]
                && shadow_reg[`CFW_KEY_AUTO_BIT];
            keying_manual_next = shadow_reg[`CFW_KEY_EN_BIT]
                && !shadow_reg[`CFW_KEY_AUTO_BIT];
            // pin only counts in enabled manual keying
            keying_pin_gate_next = shadow_reg[`CFW_KEY_EN_BIT]
                && !shadow_reg[`CFW_KEY_AUTO_BIT]
                && shadow_reg[`CFW_KEY_PIN_BIT];
            inv_sinc_next = shadow_reg[`CFW_INV_SINC_BIT];
            // sine choice matters in single tone only; elsewhere cosine
            tone_sine_next = (shadow_reg[`CFW_MODE_HI_BIT:`CFW_MODE_LO_BIT] == `CFW_MODE_TONE)
                && shadow_reg[`CFW_SINE_SEL_BIT];
        end
    end

    // datapath side: pin follower, filter feed and readback
    always_comb begin
        // pin is sampled every cycle but held low while it is ignored
        keying_level_next = keying_pin_gate_reg && output_amplitude_keying_pin;
        // zeros replace samples for the whole clear, flushing the pipeline
        if (seq_force_zero) begin
            sample_next = '0;
        end else begin
            sample_next = baseband_sample;
        end
        acc_reset_next = seq_acc_reset;
        clear_busy_next = seq_busy || clear_start;
        // unmapped addresses read as zero
        if (reg_addr == `CFW_ADDR) begin
            rdata_next = shadow_reg;
        end else begin
            rdata_next = '0;
        end
    end

    // registers only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shadow_reg <= `CFW_RESET;
            profile_reg <= '0;
            playback_enable_reg <= 1'b0;
            playback_to_iq_reg <= 1'b0;
            playback_to_scaling_reg <= 1'b0;
            mode_reg <= MODE_QUADRATURE;
            keying_enable_reg <= 1'b0;
            keying_auto_reg <= 1'b0;
            keying_manual_reg <= 1'b0;
            keying_pin_gate_reg <= 1'b0;
            keying_level_reg <= 1'b0;
            inv_sinc_reg <= 1'b0;
            tone_sine_reg <= 1'b0;
            rdata_reg <= '0;
            sample_reg <= '0;
            acc_reset_reg <= 1'b0;
            clear_busy_reg <= 1'b0;
        end else begin
            shadow_reg <= shadow_next;
            profile_reg <= profile_next;
            playback_enable_reg <= playback_enable_next;
            playback_to_iq_reg <= playback_to_iq_next;
            playback_to_scaling_reg <= playback_to_scaling_next;
            mode_reg <= mode_next;
            keying_enable_reg <= keying_enable_next;
            keying_auto_reg <= keying_auto_next;
            keying_manual_reg <= keying_manual_next;
            keying_pin_gate_reg <= keying_pin_gate_next;
            keying_level_reg <= keying_level_next;
            inv_sinc_reg <= inv_sinc_next;
            tone_sine_reg <= tone_sine_next;
            rdata_reg <= rdata_next;
            sample_reg <= sample_next;
            acc_reset_reg <= acc_reset_next;
            clear_busy_reg <= clear_busy_next;
        end
    end

    // outputs, each straight from its flop
    assign reg_rdata = rdata_reg;
    assign comb_integrator_filter_sample = sample_reg;
    assign comb_integrator_filter_acc_reset = acc_reset_reg;
    assign comb_integrator_filter_clear_busy = clear_busy_reg;
    assign playback_enable = playback_enable_reg;
    assign playback_to_iq = playback_to_iq_reg;
    assign playback_to_scaling = playback_to_scaling_reg;
    assign operating_mode = mode_reg;
    assign keying_enable = keying_enable_reg;
    assign keying_auto = keying_auto_reg;
    assign keying_manual = keying_manual_reg;
    assign keying_pin_level = keying_level_reg;
    assign inverse_sinc_enable = inv_sinc_reg;
    assign tone_sine_select = tone_sine_reg;
endmodule // control_function_word_upper

`default_nettype wire

// [hdl/control_word_defines.svh]
// Function
// - playback runs only while bit 31 set
// - bit 28 routes playback to I/Q path
// - mode field: 00 quad, 01 tone, 1x DAC
// - bit 23 lets keying pin drive manual keying
// - bit 22 inserts inverse sinc filter
// - bit 21 starts filter clear, self-clears
// - clear flushes zeros, then resets accumulators
// - bit 16 picks sine in single tone
// - writes wait for transfer strobe or profile change
// - bit 9 enables keying, bit 8 picks auto
`ifndef CONTROL_WORD_DEFINES_SVH
`define CONTROL_WORD_DEFINES_SVH

// serial address of the control word
`define CFW_ADDR 5'h00
// value after reset, every field cleared
`define CFW_RESET 32'h0000_0000
// bits that hold storage; everything else is open and reads zero
`define CFW_WRITE_MASK 32'h93e1_0300
// field positions
`define CFW_PLAYBACK_EN_BIT 31
`define CFW_PLAYBACK_DEST_BIT 28
`define CFW_MODE_HI_BIT 25
`define CFW_MODE_LO_BIT 24
`define CFW_KEY_PIN_BIT 23
`define CFW_INV_SINC_BIT 22
`define CFW_FILTER_CLEAR_BIT 21
`define CFW_SINE_SEL_BIT 16
`define CFW_KEY_EN_BIT 9
`define CFW_KEY_AUTO_BIT 8
// mode field codes
`define CFW_MODE_QUAD 2'b00
`define CFW_MODE_TONE 2'b01
// clear sequence default lengths in clock cycles
`define CLEAR_FLUSH_CYCLES 16
`define CLEAR_RESET_CYCLES 4

`endif

// [hdl/control_word_pkg.sv]
package control_word_pkg;
    // decoded operating mode, one-hot
    typedef enum logic [2:0] {
        MODE_QUADRATURE = 3'b001,
        MODE_SINGLE_TONE = 3'b010,
        MODE_INTERP_DAC = 3'b100
    } op_mode_t;

    // filter clear sequencer states, one-hot
    typedef enum logic [2:0] {
        CLR_IDLE = 3'b001,
        CLR_FLUSH = 3'b010,
        CLR_RESET = 3'b100
    } clear_state_t;
endpackage

// [hdl/filter_clear_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "control_word_defines.svh"

module filter_clear_seq #(
    parameter int FLUSH_CYCLES = `CLEAR_FLUSH_CYCLES,
    parameter int RESET_CYCLES = `CLEAR_RESET_CYCLES,
    parameter int CNT_W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    output logic force_zero,
    output logic acc_reset,
    output logic busy,
    output logic done
);
    import control_word_pkg::*;

    clear_state_t state_reg, state_next; // sequencer state
    logic [CNT_W-1:0] count_reg, count_next; // cycles left in phase
    logic force_zero_reg, force_zero_next; // zero feed to filter input
    logic acc_reset_reg, acc_reset_next; // accumulator reset strobe
    logic done_reg, done_next; // one-cycle end marker

    // phase lengths at counter width, less one because the count ends at zero
    localparam logic [CNT_W-1:0] FLUSH_LAST = CNT_W'(FLUSH_CYCLES - 1);
    localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_CYCLES - 1);

    // next state: flush the pipeline with zeros first, then reset the
    // accumulators; resetting first would let stale samples refill them
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        force_zero_next = force_zero_reg;
        acc_reset_next = acc_reset_reg;
        done_next = 1'b0;
        unique case (state_reg)
            CLR_IDLE: begin
                // a start while busy is dropped; the top holds it off anyway
                if (start) begin
                    state_next = CLR_FLUSH;
                    count_next = FLUSH_LAST;
                    force_zero_next = 1'b1;
                end
            end
            CLR_FLUSH: begin
                if (count_reg == '0) begin
                    state_next = CLR_RESET;
                    count_next = RESET_LAST;
                    acc_reset_next = 1'b1;
                end else begin
                    count_next = count_reg - 1'b1;
                end
            end
            CLR_RESET: begin
                if (count_reg == '0) begin
                    state_next = CLR_IDLE;
                    force_zero_next = 1'b0;
                    acc_reset_next = 1'b0;
                    done_next = 1'b1;
                end else begin
                    count_next = count_reg - 1'b1;
                end
            end
        endcase
    end

    // registers only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= CLR_IDLE;
            count_reg <= '0;
            force_zero_reg <= 1'b0;
            acc_reset_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            force_zero_reg <= force_zero_next;
            acc_reset_reg <= acc_reset_next;
            done_reg <= done_next;
        end
    end

    assign force_zero = force_zero_reg;
    assign acc_reset = acc_reset_reg;
    assign busy = force_zero_reg;
    assign done = done_reg;
endmodule // filter_clear_seq

`default_nettype wire

// [test/control_function_word_upper_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module control_function_word_upper_checker #(
    parameter int SAMPLE_W = 18,
    parameter int FLUSH_CYCLES = 16,
    parameter int RESET_CYCLES = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic io_update,
    input wire logic [2:0] profile,
    input wire logic output_amplitude_keying_pin,
    input wire logic [31:0] reg_rdata,
    input wire logic [SAMPLE_W-1:0] comb_integrator_filter_sample,
    input wire logic comb_integrator_filter_acc_reset,
    input wire logic comb_integrator_filter_clear_busy,
    input wire logic playback_enable,
    input wire logic playback_to_iq,
    input wire logic playback_to_scaling,
    input wire control_word_pkg::op_mode_t operating_mode,
    input wire logic keying_enable,
    input wire logic keying_auto,
    input wire logic keying_manual,
    input wire logic keying_pin_level,
    input wire logic inverse_sinc_enable,
    input wire logic tone_sine_select
);
    import control_word_pkg::*;
    logic [7:0] busy_cnt_reg; // cycles the clear has been running
    logic [7:0] busy_cnt_next;
    // count busy cycles so the clear phases can be timed without long repetitions
    always_comb begin
        busy_cnt_next = comb_integrator_filter_clear_busy ? busy_cnt_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_cnt_reg <= 8'h00;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_playback;
        ((playback_to_iq | playback_to_scaling) == playback_enable) && !(playback_to_iq && playback_to_scaling);
    endproperty
    a_playback: assert property (p_playback) else $error("playback routing inconsistent");
    property p_keying;
        ((keying_auto | keying_manual) == keying_enable) && !(keying_auto && keying_manual);
    endproperty
    a_keying: assert property (p_keying) else $error("keying select inconsistent");
    property p_key_pin;
        keying_pin_level |-> $past(keying_manual) && $past(output_amplitude_keying_pin);
    endproperty
    a_key_pin: assert property (p_key_pin) else $error("keying pin passed while gated");
    property p_tone;
        tone_sine_select |-> operating_mode == MODE_SINGLE_TONE;
    endproperty
    a_tone: assert property (p_tone) else $error("sine select outside single tone");
    property p_mode;
        $onehot(operating_mode);
    endproperty
    a_mode: assert property (p_mode) else $error("operating mode not one-hot");
    property p_open;
        (reg_rdata & 32'h6c1e_fcff) == 32'h0000_0000;
    endproperty
    a_open: assert property (p_open) else $error("open bit read back as one");
    // without io_update or a profile change the applied controls must not move
    property p_hold;
        !io_update && $stable(profile) |=> $stable(operating_mode) && $stable(inverse_sinc_enable)
            && $stable(playback_enable) && $stable(keying_enable);
    endproperty
    a_hold: assert property (p_hold) else $error("controls changed without transfer");
    property p_flush;
        $rose(comb_integrator_filter_clear_busy) |-> ##1 (comb_integrator_filter_sample == '0)[*8];
    endproperty
    a_flush: assert property (p_flush) else $error("samples not flushed as zero");
    property p_acc;
        $rose(comb_integrator_filter_acc_reset) |-> comb_integrator_filter_clear_busy
            && busy_cnt_reg >= FLUSH_CYCLES && comb_integrator_filter_sample == '0;
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator reset before flush");
    property p_bound;
        busy_cnt_reg <= FLUSH_CYCLES + RESET_CYCLES + 4;
    endproperty
    a_bound: assert property (p_bound) else $error("filter clear never completes");
    property p_start;
        $rose(comb_integrator_filter_clear_busy) |-> $past(io_update) || ($past(profile) != $past(profile, 2));
    endproperty
    a_start: assert property (p_start) else $error("clear started without transfer");
    c_clear: cover property ($rose(comb_integrator_filter_clear_busy));
    c_tone: cover property (tone_sine_select);
    c_pin: cover property (keying_pin_level);
endmodule // control_function_word_upper_checker
bind control_function_word_upper control_function_word_upper_checker #(.SAMPLE_W(SAMPLE_W),
    .FLUSH_CYCLES(FLUSH_CYCLES), .RESET_CYCLES(RESET_CYCLES)) i_control_function_word_upper_checker (
    .clock, .rst, .io_update, .profile, .output_amplitude_keying_pin, .reg_rdata,
    .comb_integrator_filter_sample, .comb_integrator_filter_acc_reset,
    .comb_integrator_filter_clear_busy, .playback_enable, .playback_to_iq, .playback_to_scaling,
    .operating_mode, .keying_enable, .keying_auto, .keying_manual, .keying_pin_level,
    .inverse_sinc_enable, .tone_sine_select);
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import control_word_pkg::*;
    logic clock, rst, reg_write, io_update, output_amplitude_keying_pin;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0] profile;
    logic [17:0] baseband_sample, comb_integrator_filter_sample;
    logic comb_integrator_filter_acc_reset, comb_integrator_filter_clear_busy;
    logic playback_enable, playback_to_iq, playback_to_scaling, keying_enable, keying_auto;
    logic keying_manual, keying_pin_level, inverse_sinc_enable, tone_sine_select;
    op_mode_t operating_mode;
    int n_tests, n_mismatch, n_acc, n_zero;
    logic [1:0] mc; // mode code under test
    control_function_word_upper #(.SAMPLE_W(18), .FLUSH_CYCLES(16), .RESET_CYCLES(4))
        i_control_function_word_upper (.clock, .rst, .reg_addr, .reg_write, .reg_wdata, .reg_rdata,
        .io_update, .profile, .output_amplitude_keying_pin, .baseband_sample,
        .comb_integrator_filter_sample, .comb_integrator_filter_acc_reset,
        .comb_integrator_filter_clear_busy, .playback_enable, .playback_to_iq, .playback_to_scaling,
        .operating_mode, .keying_enable, .keying_auto, .keying_manual, .keying_pin_level,
        .inverse_sinc_enable, .tone_sine_select);
    // free-running 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // whole-word write, address falls back to the control word afterwards
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_write = 1'b1;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
        reg_addr = 5'h00;
    endtask
    // two edges cover the registered read path
    task automatic rd(input logic [31:0] exp);
        repeat (2) @(negedge clock);
        chk(reg_rdata, exp);
    endtask
    task automatic upd();
        @(negedge clock);
        io_update = 1'b1;
        @(negedge clock);
        io_update = 1'b0;
    endtask
    // bounded wait on the clear flag, tallying reset and zero-sample cycles
    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 100 && comb_integrator_filter_clear_busy !== lvl; i++) begin
            @(negedge clock);
            n_acc += int'(comb_integrator_filter_acc_reset === 1'b1);
            n_zero += int'(comb_integrator_filter_sample === 18'h0_0000);
        end
        chk(32'(comb_integrator_filter_clear_busy), 32'(lvl));
        if (i == 100) begin
            print_verdict();
        end
    endtask
    initial begin
        rst = 1'b1;
        reg_addr = 5'h00;
        reg_write = 1'b0;
        reg_wdata = 32'h0000_0000;
        io_update = 1'b0;
        profile = 3'h0;
        output_amplitude_keying_pin = 1'b0;
        baseband_sample = 18'h2_5a5a;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        // reset state of the applied controls
        chk(32'(operating_mode), 32'(MODE_QUADRATURE));
        chk(32'({playback_enable, inverse_sinc_enable, tone_sine_select}), 32'h0);
        rd(32'h0000_0000);
        // open bits must read zero; nothing applies before a transfer
        wr(5'h00, 32'hffdf_ffff);
        rd(32'h93c1_0300);
        chk(32'(playback_enable), 32'h0);
        upd();
        chk(32'({playback_enable, playback_to_iq, inverse_sinc_enable, keying_auto}), 32'hf);
        chk(32'(tone_sine_select), 32'h0);
        // other addresses neither store nor read back
        wr(5'h01, 32'h0000_0000);
        rd(32'h93c1_0300);
        reg_addr = 5'h01;
        rd(32'h0000_0000);
        reg_addr = 5'h00;
        // every mode code, with routing, sinc and keying bits following the code
        for (int m = 0; m < 4; m++) begin
            mc = 2'(m);
            wr(5'h00, {mc[0], 2'b00, mc[1], 2'b00, mc, 1'b0, mc[1], 5'h00, 1'b1, 6'h00, mc, 8'h00});
            upd();
            chk(32'(operating_mode), mc == 2'b00 ? 32'h1 : mc == 2'b01 ? 32'h2 : 32'h4);
            chk(32'(tone_sine_select), 32'(mc == 2'b01));
            chk(32'({playback_enable, playback_to_iq, playback_to_scaling}),
                32'({mc[0], &mc, mc[0] & ~mc[1]}));
            // bit 9 enables keying and bit 8 picks auto, so the code's upper bit enables
            chk(32'({keying_enable, keying_auto, keying_manual}),
                32'({mc[1], &mc, mc[1] & ~mc[0]}));
            chk(32'(inverse_sinc_enable), 32'(mc[1]));
        end
        // external keying pin only counts in manual keying with bit 23 set
        wr(5'h00, 32'h0080_0200);
        upd();
        output_amplitude_keying_pin = 1'b1;
        repeat (2) @(negedge clock);
        chk(32'(keying_pin_level), 32'h1);
        output_amplitude_keying_pin = 1'b0;
        repeat (2) @(negedge clock);
        chk(32'(keying_pin_level), 32'h0);
        output_amplitude_keying_pin = 1'b1;
        wr(5'h00, 32'h0000_0200);
        upd();
        repeat (2) @(negedge clock);
        chk(32'(keying_pin_level), 32'h0);
        // a profile change alone transfers the buffered word
        wr(5'h00, 32'h0040_0000);
        repeat (2) @(negedge clock);
        chk(32'(inverse_sinc_enable), 32'h0);
        profile = 3'h5;
        @(negedge clock);
        chk(32'(inverse_sinc_enable), 32'h1);
        // filter clear: flush zeros, reset accumulators, then drop the request bit
        chk(32'(comb_integrator_filter_sample), 32'h2_5a5a);
        wr(5'h00, 32'h0020_0000);
        rd(32'h0020_0000);
        chk(32'(comb_integrator_filter_clear_busy), 32'h0);
        upd();
        n_acc = 0;
        n_zero = 0;
        wait_busy(1'b0);
        chk(32'(n_acc), 32'h4);
        chk(32'(n_zero >= 16), 32'h1);
        rd(32'h0000_0000);
        chk(32'(comb_integrator_filter_sample), 32'h2_5a5a);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
